// file: core/tmc_defines.svh
// Register offsets, field positions, reset values and timing counts of the timer
// Notes on behaviour
// - Source select clear: count every instruction cycle
// - Count write inhibits counting two cycles
// - Source select set: count external pin edges
// - Edge select clear rising, set falling
// - External input synchronized before use, delayed
// - Eight-bit prescaler, not software accessible
// - Assigned prescaler divides 1:2 to 1:256
// - Count write clears prescaler when assigned, keeps assignment
// - Prescaler assignment changeable while running
// - Overflow flag on FFh or FFFFh wrap
// - Interrupt request only while enable set
// - Overflow interrupt never wakes from sleep
// - Low byte read in 16-bit mode copies high byte
// - Live high byte only reached via buffer
// - Low byte write loads buffered high byte
// - Timer-on bit starts and stops counting
// - Width select set 8-bit, clear 16-bit
// - Ratio field 000 1:2 doubling to 1:256
// - Bypass bit set skips prescaler
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH
// =====================================================================
// Register offsets (byte addresses)
`define TMC_OFF_COUNT_LOW 4'h0
`define TMC_OFF_COUNT_HIGH 4'h4
`define TMC_OFF_INT_CTRL 4'h8
`define TMC_OFF_TIMER_CTRL 4'hC
// =====================================================================
// Field positions
`define TMC_TC_ON 7
`define TMC_TC_WIDTH 6
`define TMC_TC_SRC 5
`define TMC_TC_EDGE 4
`define TMC_TC_BYPASS 3
`define TMC_IC_ENABLE 5
`define TMC_IC_FLAG 2
// =====================================================================
// Reset values and timing
`define TMC_RST_TIMER_CTRL 8'hFF
`define TMC_RST_HIGH_BUF 8'h00
`define TMC_RST_INT_CTRL 8'h00
`define TMC_INHIBIT_CYCLES 2'h2
`endif

// file: core/tmc_pkg.sv
// Types shared by the timer files
package tmc_pkg;
  typedef struct packed {
    logic on;
    logic width8;
    logic src_ext;
    logic edge_fall;
    logic bypass;
    logic [2:0] ratio;
  } tmc_ctrl_t;
  typedef struct packed {
    logic [3:0] adr;
    logic we;
    logic [7:0] dat;
  } tmc_req_t;
endpackage

// file: core/tmc_prescaler.sv
// Eight-bit prescaler that divides count ticks by 2 to 256
`timescale 1ns/1ps
module tmc_prescaler #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [2:0] ratio_i,
  output logic tick_o
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic [WIDTH-1:0] mask;
  // Ratio 000 gives 1:2, each step doubles
  assign mask = WIDTH'((9'h002 << ratio_i) - 9'h001);
  assign cnt_d = cnt_q + WIDTH'(1);
  assign tick_o = tick_i && ((cnt_q & mask) == mask);
  // Internal only: no software port reaches cnt_q
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (clear_i) begin
        cnt_q <= '0;
      end else if (tick_i) begin
        cnt_q <= cnt_d;
      end
    end
  end
endmodule // tmc_prescaler

// file: core/tmc_timer.sv
// Eight/sixteen-bit timer-counter with prescaler and Wishbone register slave
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "tmc_defines.svh"
module tmc_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_count_i,
  input wire logic sleep_i,
  output logic irq_o,
  output tmc_pkg::tmc_ctrl_t ctrl_o
);
  import tmc_pkg::*;
  // =====================================================================
  // Bus decode
  logic ack_q;
  logic [31:0] rdat_q;
  logic acc;
  logic wr_lane0;
  logic rd;
  logic wr_low;
  logic wr_high;
  logic wr_ic;
  logic wr_tc;
  logic rd_low;
  tmc_req_t req;
  assign req = '{adr: wb_adr_i, we: wb_we_i, dat: wb_dat_i[7:0]};
  // One wait state per access; ack falls the cycle after it rises
  assign acc = wb_cyc_i && wb_stb_i && !ack_q && ce_i;
  assign wr_lane0 = acc && req.we && wb_sel_i[0];
  assign rd = acc && !req.we;
  assign wr_low = wr_lane0 && (req.adr == `TMC_OFF_COUNT_LOW);
  assign wr_high = wr_lane0 && (req.adr == `TMC_OFF_COUNT_HIGH);
  assign wr_ic = wr_lane0 && (req.adr == `TMC_OFF_INT_CTRL);
  assign wr_tc = wr_lane0 && (req.adr == `TMC_OFF_TIMER_CTRL);
  assign rd_low = rd && (req.adr == `TMC_OFF_COUNT_LOW);
  // =====================================================================
  // Registers
  tmc_ctrl_t ctrl_q;
  logic [7:0] low_q;
  logic [7:0] high_q;
  logic [7:0] hbuf_q;
  logic [7:0] ic_q;
  logic flag_q;
  logic [1:0] inhibit_q;
  logic [7:0] ic_rd;
  assign ctrl_o = ctrl_q;
  assign ic_rd = {ic_q[7:3], flag_q, ic_q[1:0]};
  // =====================================================================
  // External input path
  logic sync1_q;
  logic sync2_q;
  logic last_q;
  logic ext_edge;
  // Second stage feeds the detector; first stage read by nothing else
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q <= 1'b0;
    end else if (ce_i) begin
      sync1_q <= ext_count_i;
      sync2_q <= sync1_q;
      last_q <= sync2_q;
    end
  end
  assign ext_edge = ctrl_q.edge_fall ? (last_q && !sync2_q) : (!last_q && sync2_q);
  // =====================================================================
  // Tick generation
  logic raw_tick;
  logic pre_tick;
  logic tick;
  logic low_wrap;
  logic full_wrap;
  logic [7:0] low_inc;
  logic [7:0] high_inc;
  assign raw_tick = ctrl_q.src_ext ? ext_edge : 1'b1;
  tmc_prescaler #(.WIDTH(8)) u_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(wr_low && !ctrl_q.bypass),
    .tick_i(raw_tick && ctrl_q.on),
    .ratio_i(ctrl_q.ratio),
    .tick_o(pre_tick)
  );
  // Bypass read live each cycle, so reassignment works while running
  assign tick = ctrl_q.on && (inhibit_q == 2'h0) &&
    (ctrl_q.bypass ? raw_tick : pre_tick);
  assign low_inc = low_q + 8'h01;
  assign high_inc = high_q + 8'h01;
  assign low_wrap = tick && (low_q == 8'hFF);
  assign full_wrap = low_wrap && (ctrl_q.width8 || (high_q == 8'hFF));
  // =====================================================================
  // Count state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_q <= 8'h00;
      high_q <= 8'h00;
      inhibit_q <= 2'h0;
    end else if (ce_i) begin
      if (wr_low) begin
        low_q <= req.dat;
        high_q <= hbuf_q;
        inhibit_q <= `TMC_INHIBIT_CYCLES;
      end else begin
        if (inhibit_q != 2'h0) begin
          inhibit_q <= inhibit_q - 2'h1;
        end
        if (tick) begin
          low_q <= low_inc;
        end
        if (low_wrap && !ctrl_q.width8) begin
          high_q <= high_inc;
        end
      end
    end
  end
  // =====================================================================
  // Control, buffer and flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `TMC_RST_TIMER_CTRL;
      hbuf_q <= `TMC_RST_HIGH_BUF;
      ic_q <= `TMC_RST_INT_CTRL;
      flag_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_tc) begin
        ctrl_q <= req.dat;
      end
      if (wr_high) begin
        hbuf_q <= req.dat;
      end else if (rd_low && !ctrl_q.width8) begin
        hbuf_q <= high_q;
      end
      if (wr_ic) begin
        ic_q <= req.dat;
      end
      // Set wins over a software clear in the same cycle
      if (full_wrap) begin
        flag_q <= 1'b1;
      end else if (wr_ic) begin
        flag_q <= req.dat[`TMC_IC_FLAG];
      end
    end
  end
  // Sleep blocks the request so it can never act as a wake source
  assign irq_o = flag_q && ic_q[`TMC_IC_ENABLE] && !sleep_i;
  // =====================================================================
  // Read data and acknowledge
  logic [7:0] rsel;
  assign rsel = (req.adr == `TMC_OFF_COUNT_LOW) ? low_q :
    (req.adr == `TMC_OFF_COUNT_HIGH) ? hbuf_q :
    (req.adr == `TMC_OFF_INT_CTRL) ? ic_rd :
    (req.adr == `TMC_OFF_TIMER_CTRL) ? ctrl_q : 8'h00;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= acc;
      if (rd) begin
        rdat_q <= {24'h00_0000, rsel};
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
endmodule // tmc_timer

// file: testbench/tmc_timer_properties.sv
// Concurrent checks on the timer ports
`timescale 1ns/1ps
module tmc_timer_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sleep_i,
  input wire logic irq_o,
  input wire tmc_pkg::tmc_ctrl_t ctrl_o
);
  import tmc_pkg::*;
  // ==========================================
  // Handshake and register properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  wire wr0 = take && wb_we_i && wb_sel_i[0];
  wire ctl_wr = wr0 && wb_adr_i == 4'hC;
  sequence take_s;
    take;
  endsequence
  ack_answer_a: assert property (take_s |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack long");
  ack_cause_a: assert property (!take && ce_i |=> !wb_ack_o) else $error("stray ack");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper");
  sleep_mask_a: assert property (sleep_i |-> !irq_o) else $error("irq in sleep");
  irq_mask_a: assert property (wr0 && wb_adr_i == 4'h8 && !wb_dat_i[5] |=> !irq_o)
    else $error("irq unmasked");
  ctrl_load_a: assert property (ctl_wr |=> ctrl_o == 8'($past(wb_dat_i)))
    else $error("ctrl load");
  ctrl_hold_a: assert property (!ctl_wr |=> $stable(ctrl_o)) else $error("ctrl moved");
  ctrl_reset_a: assert property (disable iff (1'b0) rst_i && ce_i |=> ctrl_o == 8'hFF)
    else $error("ctrl reset");
endmodule // tmc_timer_properties

bind tmc_timer tmc_timer_properties u_tmc_timer_properties (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sleep_i,
  .irq_o, .ctrl_o);

// file: testbench/tmc_timer_tb.sv
// Register-level bench for the timer
`timescale 1ns/1ps
module tmc_timer_tb;
  import tmc_pkg::*;
  // ==========================================
  // Bus, clock and checks
  logic clk = 1'h0, rst = 1'h1, cyc = 1'h0, we = 1'h0, ext = 1'h0, slp = 1'h0, ack, irq;
  logic ce = 1'h1;
  logic [3:0] adr = 4'h0, sel = 4'h1;
  logic [31:0] wd = 32'h0, dq;
  logic [7:0] rd, ex;
  tmc_ctrl_t ctl;
  int n_errors = 0, cmp_count = 0, cyc_n = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc_n <= cyc_n + 1;
  always @(posedge clk) if (cyc_n == 9000) begin
    n_errors++;
    close_out();
  end
  tmc_timer u_tmc_timer (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dq), .wb_ack_o(ack),
    .ext_count_i(ext), .sleep_i(slp), .irq_o(irq), .ctrl_o(ctl));
  task automatic close_out();
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Reads are taken three cycles apart, so running counts are exact
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    adr <= a;
    we <= w;
    wd <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'h1);
    rd = dq[7:0];
    cyc <= 1'h0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(a, 1'h1, d);
  endtask
  task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
    bus(a, 1'h0, 8'h00);
    chk(n, e, rd);
  endtask
  task automatic ichk(input logic e);
    @(negedge clk);
    chk("irq", {7'h0, e}, {7'h0, irq});
    @(posedge clk);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reg();
    rchk("ctl", 4'hC, 8'hFF);
    rchk("hbuf", 4'h4, 8'h00);
    rchk("ictl", 4'h8, 8'h00);
    rchk("unmap", 4'h1, 8'h00);
    sel <= 4'h0;
    wr(4'hC, 8'h00);
    sel <= 4'h1;
    rchk("selw", 4'hC, 8'hFF);
  endtask
  task automatic t_tmr();
    wr(4'hC, 8'hC8);
    wr(4'h0, 8'h10);
    rchk("inh", 4'h0, 8'h10);
    rchk("run", 4'h0, 8'h13);
    wr(4'hC, 8'h48);
    wr(4'h0, 8'h55);
    repeat (5) @(posedge clk);
    rchk("stop", 4'h0, 8'h55);
  endtask
  task automatic t_wide();
    wr(4'hC, 8'h88);
    wr(4'h4, 8'h12);
    wr(4'h0, 8'hFF);
    rchk("lo", 4'h0, 8'hFF);
    rchk("hi", 4'h4, 8'h12);
    rchk("lo2", 4'h0, 8'h05);
    rchk("hi2", 4'h4, 8'h13);
    wr(4'h4, 8'h77);
    bus(4'h0, 1'h0, 8'h00);
    rchk("hi3", 4'h4, 8'h13);
  endtask
  task automatic t_irq();
    wr(4'hC, 8'hC8);
    wr(4'h8, 8'h20);
    wr(4'h0, 8'hF0);
    repeat (30) @(posedge clk);
    ichk(1'h1);
    rchk("flag", 4'h8, 8'h24);
    slp <= 1'h1;
    ichk(1'h0);
    slp <= 1'h0;
    wr(4'h8, 8'h04);
    ichk(1'h0);
    rchk("keep", 4'h8, 8'h04);
    wr(4'h8, 8'h20);
    ichk(1'h0);
  endtask
  // Phase of the inhibit against the divider is open, so allow one count
  task automatic t_psc();
    for (int r = 0; r < 8; r++) begin
      wr(4'hC, 8'hC0 | 8'(r));
      wr(4'h0, 8'h00);
      repeat (400) @(posedge clk);
      bus(4'h0, 1'h0, 8'h00);
      ex = 8'(400 >> (r + 1));
      chk("psc", ex, (rd == ex + 8'h1 || rd + 8'h1 == ex) ? ex : rd);
    end
  endtask
  // Enable low freezes count and inhibit, so the write value is read back unchanged
  task automatic t_ce();
    wr(4'hC, 8'hC8);
    wr(4'h0, 8'h20);
    ce <= 1'h0;
    repeat (10) @(posedge clk);
    ce <= 1'h1;
    rchk("freeze", 4'h0, 8'h20);
  endtask
  task automatic t_ext(input logic [7:0] c, input logic [7:0] e);
    ext <= 1'h0;
    wr(4'hC, c);
    wr(4'h0, 8'h00);
    repeat (5) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      ext <= ~ext;
      repeat (4) @(posedge clk);
    end
    ext <= 1'h1;
    rchk("sync", 4'h0, 8'h03);
    repeat (5) @(posedge clk);
    rchk("edge", 4'h0, e);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    t_reg();
    t_tmr();
    t_wide();
    t_irq();
    t_psc();
    t_ce();
    t_ext(8'hE8, 8'h04);
    t_ext(8'hF8, 8'h03);
    close_out();
  end
endmodule // tmc_timer_tb
